// ### rtl/asau_pkg.sv
// constants, opcodes and states of the accumulator stack arithmetic unit
// Notes on behaviour
// [RULE1] bcd add: accumulator plus stack level one, sum into accumulator
// [RULE2] add, subtract, multiply and binary add pop level one, deeper entries move up
// [RULE3] bcd subtract: accumulator minus stack level one, difference into accumulator
// [RULE4] bcd multiply: four-digit level one times four-digit accumulator, product into accumulator
// [RULE5] bcd divide: eight-digit accumulator by four-digit level one, quotient into accumulator
// [RULE6] bcd divide puts remainder into level one and does not pop
// [RULE7] binary add: accumulator plus level one, binary sum into accumulator
// [RULE8] all five operations set zero flag when result is zero, else clear
// [RULE9] bcd and binary add set carry flag on carry out, else clear
// [RULE10] bcd subtract sets borrow flag on borrow, else clear
// [RULE11] all five operations set negative flag when result is negative
// [RULE12] bcd add, bcd subtract and binary add set sign error on overflow
// [RULE13] bcd operations flag any invalid operand digit; binary add leaves it
// [RULE14] bcd divide sets overrange flag when operand exceeds what accumulator handles
// [RULE15] flags hold until an operation that affects that flag rewrites it
// [RULE16] accumulator load first pushes old accumulator into level one
// [RULE17] result, stack and flags of an operation commit on one edge
// [RULE18] sequencer issues next opcode only after previous one completed
package asau_pkg;
  localparam int ASAU_AW = 8;
  localparam int ASAU_DW = 32;
  localparam int ASAU_DEPTH = 8;
  localparam int ASAU_DIGITS = 8;
  localparam int ASAU_MUL_DIGITS = 4;
  // register byte offsets
  localparam logic [7:0] ASAU_OFF_ACC = 8'h00;
  localparam logic [7:0] ASAU_OFF_STK1 = 8'h04;
  localparam logic [7:0] ASAU_OFF_CMD = 8'h08;
  localparam logic [7:0] ASAU_OFF_FLAGS = 8'h0C;
  localparam logic [7:0] ASAU_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] ASAU_OFF_IRQ_MASK = 8'h14;
  // flag register bit positions
  localparam int ASAU_FLG_ZERO = 0;
  localparam int ASAU_FLG_BORROW = 1;
  localparam int ASAU_FLG_CARRY = 2;
  localparam int ASAU_FLG_NEG = 3;
  localparam int ASAU_FLG_SERR = 4;
  localparam int ASAU_FLG_BCD = 5;
  localparam int ASAU_FLG_OVR = 6;
  localparam int ASAU_FLG_W = 7;
  // interrupt status and mask bit positions
  localparam int ASAU_IRQ_DONE = 0;
  localparam int ASAU_IRQ_BCD = 1;
  localparam int ASAU_IRQ_OVR = 2;
  localparam int ASAU_IRQ_W = 3;
  localparam int ASAU_CMD_BUSY = 0;
  // reset values and limits
  localparam logic [31:0] ASAU_ACC_RST = 32'h0000_0000;
  localparam logic [6:0] ASAU_FLG_RST = 7'h00;
  localparam logic [2:0] ASAU_MASK_RST = 3'h0;
  localparam logic [31:0] ASAU_BCD_MAX = 32'h05F5_E0FF;
  typedef enum logic [2:0] {
    ASAU_OP_NONE = 3'b000,
    ASAU_OP_ADD = 3'b001,
    ASAU_OP_SUB = 3'b010,
    ASAU_OP_MUL = 3'b011,
    ASAU_OP_DIV = 3'b100,
    ASAU_OP_BADD = 3'b101
  } asau_op_t;
  typedef enum logic {
    ASAU_ST_IDLE = 1'b0,
    ASAU_ST_EXEC = 1'b1
  } asau_state_t;
endpackage

// ### rtl/asau_core.sv
// accumulator stack arithmetic unit with apb register access and interrupt
module asau_core import asau_pkg::*; (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ASAU_AW-1:0] paddr,
  input wire logic [ASAU_DW-1:0] pwdata,
  output logic [ASAU_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  // decimal add of eight digits with carry in; bit 32 is decimal carry out
  function automatic logic [32:0] asau_bcd_add(input logic [31:0] a, input logic [31:0] b, input logic cin);
    logic [4:0] s;
    logic c;
    logic [31:0] r;
    c = cin;
    r = 32'h0000_0000;
    for (int i = 0; i < ASAU_DIGITS; i++) begin
      s = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
      if (s > 5'h09) begin
        s = s + 5'h06;
        c = 1'b1;
      end else begin
        c = 1'b0;
      end
      r[4*i+:4] = s[3:0];
    end
    return {c, r};
  endfunction

  // nines complement of eight digits
  function automatic logic [31:0] asau_nines(input logic [31:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < ASAU_DIGITS; i++) begin
      r[4*i+:4] = 4'h9 - a[4*i+:4];
    end
    return r;
  endfunction

  // true when the low n digits are all decimal
  function automatic logic asau_bcd_ok(input logic [31:0] a, input int n);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < ASAU_DIGITS; i++) begin
      if (i < n && a[4*i+:4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // decimal to binary
  function automatic logic [31:0] asau_to_bin(input logic [31:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = ASAU_DIGITS - 1; i >= 0; i--) begin
      r = 32'(r * 32'd10) + {28'h0000000, a[4*i+:4]};
    end
    return r;
  endfunction

  // binary to decimal by shift and add three; digits above eight are dropped
  function automatic logic [31:0] asau_to_bcd(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 31; i >= 0; i--) begin
      for (int j = 0; j < ASAU_DIGITS; j++) begin
        if (r[4*j+:4] > 4'h4) begin
          r[4*j+:4] = r[4*j+:4] + 4'h3;
        end
      end
      r = {r[30:0], v[i]};
    end
    return r;
  endfunction

  asau_state_t st_q, st_d;
  asau_op_t op_q, op_d;
  logic [31:0] acc_q, acc_d;
  logic [31:0] stk_q [ASAU_DEPTH];
  logic [31:0] stk_d [ASAU_DEPTH];
  logic [ASAU_FLG_W-1:0] flg_q, flg_d;
  logic do_pop;
  logic evt_bcd;
  logic evt_ovr;
  logic [ASAU_IRQ_W-1:0] stat_q, stat_d;
  logic [ASAU_IRQ_W-1:0] mask_q, mask_d;
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic irq_d;
  logic apb_done;
  logic acc_wr;
  logic cmd_wr;
  logic cmd_legal;
  logic [32:0] sum_bcd;
  logic [32:0] dif_bcd;
  logic [32:0] sum_bin;
  logic [31:0] mul_bcd;
  logic [31:0] dvd_bin;
  logic [31:0] dvs_bin;
  logic [31:0] quo_bin;
  logic [31:0] rem_bin;
  logic div_ovr;
  logic ops_ok32;
  logic ops_ok16;
  logic div_ok;

  // bus decode: a write takes effect at the completing access edge
  assign apb_done = psel & penable & pready;
  assign acc_wr = apb_done & pwrite & (paddr == ASAU_OFF_ACC) & (st_q == ASAU_ST_IDLE);
  assign cmd_wr = apb_done & pwrite & (paddr == ASAU_OFF_CMD) & (st_q == ASAU_ST_IDLE);
  assign cmd_legal = (pwdata[2:0] != 3'h0) & (pwdata[2:0] < 3'h6);

  // operand arithmetic on the accumulator and stack level one
  assign sum_bcd = asau_bcd_add(acc_q, stk_q[0], 1'b0); // [RULE1]
  assign dif_bcd = asau_bcd_add(acc_q, asau_nines(stk_q[0]), 1'b1); // [RULE3]
  assign sum_bin = {1'b0, acc_q} + {1'b0, stk_q[0]}; // [RULE7]
  assign mul_bcd = asau_to_bcd(32'(asau_to_bin({16'h0000, acc_q[15:0]}) *
                                   asau_to_bin({16'h0000, stk_q[0][15:0]}))); // [RULE4]
  assign dvd_bin = asau_to_bin(acc_q);
  assign dvs_bin = asau_to_bin({16'h0000, stk_q[0][15:0]});
  assign quo_bin = (dvs_bin == 32'h0000_0000) ? 32'h0000_0000 : dvd_bin / dvs_bin; // [RULE5]
  assign rem_bin = (dvs_bin == 32'h0000_0000) ? 32'h0000_0000 : dvd_bin % dvs_bin; // [RULE6]
  assign div_ovr = (dvs_bin == 32'h0000_0000) | (quo_bin > ASAU_BCD_MAX); // [RULE14]
  assign ops_ok32 = asau_bcd_ok(acc_q, ASAU_DIGITS) & asau_bcd_ok(stk_q[0], ASAU_DIGITS);
  assign ops_ok16 = asau_bcd_ok(acc_q, ASAU_MUL_DIGITS) & asau_bcd_ok(stk_q[0], ASAU_MUL_DIGITS);
  assign div_ok = asau_bcd_ok(acc_q, ASAU_DIGITS) & asau_bcd_ok(stk_q[0], ASAU_MUL_DIGITS);

  // sequencing, accumulator, stack and flags: every result commits on the exec edge
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    acc_d = acc_q;
    stk_d = stk_q;
    flg_d = flg_q; // [RULE15]
    do_pop = 1'b0;
    evt_bcd = 1'b0;
    evt_ovr = 1'b0;
    unique case (st_q)
      ASAU_ST_IDLE: begin
        if (acc_wr) begin
          acc_d = pwdata;
          stk_d[0] = acc_q; // [RULE16]
          for (int i = 1; i < ASAU_DEPTH; i++) begin
            stk_d[i] = stk_q[i-1];
          end
        end else if (cmd_wr && cmd_legal) begin
          op_d = asau_op_t'(pwdata[2:0]);
          st_d = ASAU_ST_EXEC;
        end
      end
      ASAU_ST_EXEC: begin
        st_d = ASAU_ST_IDLE;
        unique case (op_q)
          ASAU_OP_ADD: begin
            acc_d = sum_bcd[31:0];
            do_pop = 1'b1;
            flg_d[ASAU_FLG_CARRY] = sum_bcd[32]; // [RULE9]
            flg_d[ASAU_FLG_SERR] = (acc_q[31] == stk_q[0][31]) & (sum_bcd[31] != acc_q[31]); // [RULE12]
            flg_d[ASAU_FLG_BCD] = ~ops_ok32; // [RULE13]
          end
          ASAU_OP_SUB: begin
            acc_d = dif_bcd[31:0];
            do_pop = 1'b1;
            flg_d[ASAU_FLG_BORROW] = ~dif_bcd[32]; // [RULE10]
            flg_d[ASAU_FLG_SERR] = (acc_q[31] != stk_q[0][31]) & (dif_bcd[31] != acc_q[31]); // [RULE12]
            flg_d[ASAU_FLG_BCD] = ~ops_ok32; // [RULE13]
          end
          ASAU_OP_MUL: begin
            acc_d = mul_bcd;
            do_pop = 1'b1;
            flg_d[ASAU_FLG_BCD] = ~ops_ok16; // [RULE13]
          end
          ASAU_OP_DIV: begin
            flg_d[ASAU_FLG_OVR] = div_ovr; // [RULE14]
            flg_d[ASAU_FLG_BCD] = ~div_ok; // [RULE13]
            if (!div_ovr) begin
              acc_d = asau_to_bcd(quo_bin);
              stk_d[0] = asau_to_bcd(rem_bin); // [RULE6]
            end
          end
          ASAU_OP_BADD: begin
            acc_d = sum_bin[31:0];
            do_pop = 1'b1;
            flg_d[ASAU_FLG_CARRY] = sum_bin[32]; // [RULE9]
            flg_d[ASAU_FLG_SERR] = (acc_q[31] == stk_q[0][31]) & (sum_bin[31] != acc_q[31]); // [RULE12]
          end
          default: begin
            do_pop = 1'b0;
          end
        endcase
        if (do_pop) begin
          for (int i = 0; i < ASAU_DEPTH - 1; i++) begin
            stk_d[i] = stk_q[i+1]; // [RULE2]
          end
          stk_d[ASAU_DEPTH-1] = 32'h0000_0000;
        end
        // zero and sign come from the value the accumulator will hold
        flg_d[ASAU_FLG_ZERO] = (acc_d == 32'h0000_0000); // [RULE8]
        flg_d[ASAU_FLG_NEG] = acc_d[31]; // [RULE11]
        evt_bcd = flg_d[ASAU_FLG_BCD] & (op_q != ASAU_OP_BADD);
        evt_ovr = flg_d[ASAU_FLG_OVR] & (op_q == ASAU_OP_DIV);
      end
    endcase
  end

  // core registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ASAU_ST_IDLE;
      op_q <= ASAU_OP_NONE;
      acc_q <= ASAU_ACC_RST;
      flg_q <= ASAU_FLG_RST;
      for (int i = 0; i < ASAU_DEPTH; i++) begin
        stk_q[i] <= 32'h0000_0000;
      end
    end else begin
      st_q <= st_d; // [RULE17]
      op_q <= op_d;
      acc_q <= acc_d;
      flg_q <= flg_d;
      stk_q <= stk_d;
    end
  end

  // apb read mux, one wait-free access phase, read-clear status and writable mask
  always_comb begin
    prdata_d = prdata;
    pslverr_d = pslverr;
    pready_d = psel & ~penable;
    mask_d = mask_q;
    stat_d = stat_q;
    if (psel && !penable) begin
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      unique case (paddr)
        ASAU_OFF_ACC: prdata_d = acc_q;
        ASAU_OFF_STK1: begin
          prdata_d = stk_q[0];
          pslverr_d = pwrite;
        end
        ASAU_OFF_CMD: prdata_d[ASAU_CMD_BUSY] = (st_q == ASAU_ST_EXEC);
        ASAU_OFF_FLAGS: begin
          prdata_d[ASAU_FLG_W-1:0] = flg_q;
          pslverr_d = pwrite;
        end
        ASAU_OFF_IRQ_STAT: begin
          prdata_d[ASAU_IRQ_W-1:0] = stat_q;
          pslverr_d = pwrite;
        end
        ASAU_OFF_IRQ_MASK: prdata_d[ASAU_IRQ_W-1:0] = mask_q;
        default: pslverr_d = 1'b1;
      endcase
    end
    if (apb_done && pwrite && paddr == ASAU_OFF_IRQ_MASK) begin
      mask_d = pwdata[ASAU_IRQ_W-1:0];
    end
    // clear only the bits that were returned; a new event wins over the clear
    if (apb_done && !pwrite && paddr == ASAU_OFF_IRQ_STAT) begin
      stat_d = stat_q & ~prdata[ASAU_IRQ_W-1:0];
    end
    stat_d[ASAU_IRQ_DONE] = stat_d[ASAU_IRQ_DONE] | (st_q == ASAU_ST_EXEC);
    stat_d[ASAU_IRQ_BCD] = stat_d[ASAU_IRQ_BCD] | evt_bcd;
    stat_d[ASAU_IRQ_OVR] = stat_d[ASAU_IRQ_OVR] | evt_ovr;
    irq_d = |(stat_d & mask_d);
  end

  // bus and interrupt registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      stat_q <= 3'h0;
      mask_q <= ASAU_MASK_RST;
    end else begin
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      irq <= irq_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // assertions run on the bus clock and rest while reset is held
  default clocking asau_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // one cycle of execution per accepted opcode
  logic exec;
  assign exec = (st_q == ASAU_ST_EXEC);

  // checks on results, stack and flags one edge after execution, a load, an opcode write or a cycle without execution
  add_result_a: assert property (exec && op_q == ASAU_OP_ADD |=> // [RULE1]
    acc_q == 32'(asau_bcd_add($past(acc_q), $past(stk_q[0]), 1'b0)) &&
    flg_q[ASAU_FLG_CARRY] == $past(sum_bcd[32]))
    else $error("bcd add result or carry wrong");
  pop_shift_a: assert property (exec && op_q != ASAU_OP_DIV |=> // [RULE2]
    stk_q[0] == $past(stk_q[1]) && stk_q[ASAU_DEPTH-1] == 32'h0000_0000)
    else $error("stack did not move up after operation");
  sub_borrow_a: assert property (exec && op_q == ASAU_OP_SUB && ops_ok32 |=> // [RULE10]
    flg_q[ASAU_FLG_BORROW] == ($past(asau_to_bin(acc_q)) < $past(asau_to_bin(stk_q[0]))))
    else $error("borrow flag wrong after bcd subtract");
  div_keep_a: assert property (exec && op_q == ASAU_OP_DIV |=> // [RULE6]
    stk_q[1] == $past(stk_q[1]) && (flg_q[ASAU_FLG_OVR] || asau_to_bin(stk_q[0]) < $past(dvs_bin)))
    else $error("divide popped stack or remainder too large");
  badd_sum_a: assert property (exec && op_q == ASAU_OP_BADD |=> // [RULE7]
    acc_q == $past(acc_q) + $past(stk_q[0]) && flg_q[ASAU_FLG_BCD] == $past(flg_q[ASAU_FLG_BCD]))
    else $error("binary add wrong or touched bcd flag");
  zero_neg_a: assert property (exec |=> // [RULE8]
    flg_q[ASAU_FLG_ZERO] == (acc_q == 32'h0000_0000) && flg_q[ASAU_FLG_NEG] == acc_q[31])
    else $error("zero or negative flag does not match accumulator");
  flag_hold_a: assert property (!exec |=> $stable(flg_q)) // [RULE15]
    else $error("flags changed with no operation");
  mul_carry_a: assert property (exec && op_q == ASAU_OP_MUL |=> // [RULE15]
    $stable(flg_q[ASAU_FLG_CARRY]) && $stable(flg_q[ASAU_FLG_BORROW]) && $stable(flg_q[ASAU_FLG_SERR]))
    else $error("multiply touched carry, borrow or sign error");
  push_load_a: assert property (acc_wr |=> // [RULE16]
    stk_q[0] == $past(acc_q) && acc_q == $past(pwdata) && stk_q[1] == $past(stk_q[0]))
    else $error("load did not push old accumulator");
  one_cycle_a: assert property (cmd_wr && cmd_legal |=> exec ##1 !exec) // [RULE17]
    else $error("operation did not complete in one exec cycle");

  // results and flags of the remaining operations; subtract, multiply and divide results checked against decimal values
  sub_result_a: assert property (exec && op_q == ASAU_OP_SUB && ops_ok32 |=> // [RULE3]
    asau_to_bin(acc_q) == ($past(asau_to_bin(acc_q)) + ASAU_BCD_MAX + 32'h1 - $past(asau_to_bin(stk_q[0]))) %
    (ASAU_BCD_MAX + 32'h1))
    else $error("bcd subtract difference wrong");
  mul_result_a: assert property (exec && op_q == ASAU_OP_MUL && ops_ok16 |=> // [RULE4]
    asau_to_bin(acc_q) == $past(asau_to_bin({16'h0000, acc_q[15:0]})) *
    $past(asau_to_bin({16'h0000, stk_q[0][15:0]})))
    else $error("bcd multiply product wrong");
  div_result_a: assert property (exec && op_q == ASAU_OP_DIV && div_ok && !div_ovr |=> // [RULE5] [RULE6]
    asau_to_bin(acc_q) == $past(asau_to_bin(acc_q)) / $past(asau_to_bin({16'h0000, stk_q[0][15:0]})) &&
    asau_to_bin(stk_q[0]) == $past(asau_to_bin(acc_q)) % $past(asau_to_bin({16'h0000, stk_q[0][15:0]})))
    else $error("bcd divide quotient or remainder wrong");
  bcd_flag_a: assert property (exec && (op_q == ASAU_OP_ADD || op_q == ASAU_OP_SUB) |=> // [RULE13]
    flg_q[ASAU_FLG_BCD] == !$past(ops_ok32))
    else $error("invalid digit flag wrong after bcd add or subtract");
  ovr_hold_a: assert property (exec && op_q == ASAU_OP_DIV && div_ovr |=> // [RULE14]
    flg_q[ASAU_FLG_OVR] && $stable(acc_q) && $stable(stk_q[0]))
    else $error("overrange divide changed accumulator or stack");
  badd_serr_a: assert property (exec && op_q == ASAU_OP_BADD |=> // [RULE12]
    flg_q[ASAU_FLG_SERR] == ($past(acc_q[31]) == $past(stk_q[0][31]) && acc_q[31] != $past(acc_q[31])))
    else $error("sign error flag wrong after binary add");

  // bus answer and interrupt status
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  done_sticky_a: assert property (stat_q[ASAU_IRQ_DONE] &&
    !(apb_done && !pwrite && paddr == ASAU_OFF_IRQ_STAT) |=> stat_q[ASAU_IRQ_DONE])
    else $error("done status bit lost without a status read");

  // main scenarios reached
  div_zero_c: cover property (exec && op_q == ASAU_OP_DIV && dvs_bin == 32'h0000_0000);
  add_carry_c: cover property (exec && op_q == ASAU_OP_ADD && sum_bcd[32]);
  push_add_c: cover property (acc_wr ##[1:8] exec && op_q == ASAU_OP_ADD);
  irq_rise_c: cover property (!irq ##1 irq);
  sub_borrow_c: cover property (exec && op_q == ASAU_OP_SUB && !dif_bcd[32]);

endmodule

// ### sim/asau_seq.sv
// sequencer model: apb master issuing loads, stack opcodes and register reads
module asau_seq import asau_pkg::*; (
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ASAU_AW-1:0] paddr,
  output logic [ASAU_DW-1:0] pwdata,
  input wire logic [ASAU_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one apb transfer: setup, then access held until pready is sampled high
  task automatic xfer(input logic wr, input logic [ASAU_AW-1:0] addr, input logic [ASAU_DW-1:0] wdata,
                      output logic [ASAU_DW-1:0] rdata, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~addr; // released bus must not keep stale values
    pwdata <= ~wdata;
  endtask

  // start an opcode, then issue nothing else until busy has cleared
  task automatic op(input asau_op_t code);
    logic [ASAU_DW-1:0] d;
    logic e;
    xfer(1'b1, ASAU_OFF_CMD, {29'h0, code}, d, e);
    d = 32'h1;
    while (d[ASAU_CMD_BUSY] !== 1'b0) xfer(1'b0, ASAU_OFF_CMD, 32'h0, d, e);
  endtask
endmodule

// ### sim/asau_core_tb.sv
// self-checking bench for the accumulator stack arithmetic unit
module asau_core_tb import asau_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk;
  logic rst_b;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ASAU_AW-1:0] paddr;
  logic [ASAU_DW-1:0] pwdata;
  logic [ASAU_DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  asau_core u_asau_core (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  asau_seq u_asau_seq (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic wrap_up();
    $display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    u_asau_seq.xfer(1'b0, a, 32'h0, d, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    u_asau_seq.xfer(1'b1, a, v, d, e);
  endtask

  // two loads: first value ends in level one, second in the accumulator
  task automatic pair(input logic [31:0] s, input logic [31:0] a);
    wr(ASAU_OFF_ACC, s);
    wr(ASAU_OFF_ACC, a);
  endtask

  // compare accumulator, level one (under a mask) and the flag word
  task automatic expect_state(input string tn, input logic [31:0] acc, input logic [31:0] stk,
                              input logic [31:0] flg, input logic [31:0] sm);
    logic [31:0] d;
    rd(ASAU_OFF_ACC, d);
    chk({tn, " acc"}, acc, d);
    rd(ASAU_OFF_STK1, d);
    chk({tn, " level one"}, stk & sm, d & sm);
    rd(ASAU_OFF_FLAGS, d);
    chk({tn, " flags"}, flg, d);
    $display("test %s done", tn);
  endtask

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    logic [31:0] d;
    logic e;
    rst_b = 1'b0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    expect_state("reset", 32'h0, 32'h0, 32'h0, 32'hFFFF_FFFF);
    wr(ASAU_OFF_IRQ_MASK, 32'h1);
    rd(ASAU_OFF_IRQ_MASK, d);
    chk("mask readback", 32'h1, d);
    wr(ASAU_OFF_ACC, 32'h5);
    pair(32'h19, 32'h23);
    rd(ASAU_OFF_STK1, d);
    chk("pushed level one", 32'h19, d);
    u_asau_seq.op(ASAU_OP_ADD);
    chk("irq on done", 32'h1, {31'h0, irq});
    expect_state("bcd add", 32'h42, 32'h5, 32'h0, 32'hFFFF_FFFF);
    rd(ASAU_OFF_IRQ_STAT, d);
    chk("irq status", 32'h1, d);
    repeat (3) @(posedge mclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(ASAU_OFF_IRQ_MASK, 32'h0);
    pair(32'h9999_9999, 32'h1);
    u_asau_seq.op(ASAU_OP_ADD);
    expect_state("bcd carry", 32'h0, 32'h42, 32'h05, 32'hFFFF_FFFF);
    pair(32'h25, 32'h10);
    u_asau_seq.op(ASAU_OP_SUB);
    expect_state("bcd borrow", 32'h9999_9985, 32'h0, 32'h0E, 32'hFFFF_FFFF);
    pair(32'h1234, 32'h11);
    u_asau_seq.op(ASAU_OP_MUL);
    expect_state("bcd mul", 32'h0001_3574, 32'h9999_9985, 32'h06, 32'hFFFF_FFFF);
    pair(32'h10, 32'h123);
    u_asau_seq.op(ASAU_OP_DIV);
    expect_state("bcd div", 32'h12, 32'h3, 32'h06, 32'hFFFF_FFFF);
    pair(32'h0, 32'h55);
    u_asau_seq.op(ASAU_OP_DIV);
    u_asau_seq.xfer(1'b1, ASAU_OFF_STK1, 32'h1234_5678, d, e);
    chk("level one write refused", 32'h1, {31'h0, e});
    expect_state("div overrange", 32'h55, 32'h0, 32'h46, 32'hFFFF_FFFF);
    u_asau_seq.xfer(1'b0, 8'h1C, 32'h0, d, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
    pair(32'h1, 32'hA);
    u_asau_seq.op(ASAU_OP_ADD);
    rd(ASAU_OFF_FLAGS, d);
    chk("invalid digit", 32'h20, d & 32'h20);
    pair(32'hFFFF_FFFF, 32'h1);
    u_asau_seq.op(ASAU_OP_BADD);
    expect_state("bin carry", 32'h0, 32'h11, 32'h67, 32'hFFFF_FFFF);
    pair(32'h7FFF_FFFF, 32'h1);
    u_asau_seq.op(ASAU_OP_BADD);
    expect_state("bin overflow", 32'h8000_0000, 32'h0, 32'h7A, 32'hFFFF_FFFF);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(ASAU_OFF_IRQ_STAT, d);
    chk("irq status sticky", 32'h7, d);
    u_asau_seq.xfer(1'b1, ASAU_OFF_CMD, 32'h7, d, e);
    chk("illegal opcode err", 32'h0, {31'h0, e});
    rd(ASAU_OFF_IRQ_STAT, d);
    chk("illegal opcode ignored", 32'h0, d);
    wrap_up();
  end
endmodule
